// [rtl/hcsr_charge_seq.sv]
// Automatic charging-mode attempt sequencer shared by the charging ports.
// Assumes the port logic pulses advance_i when the present mode fails.
`timescale 1ns/1ps
`default_nettype none
module hcsr_charge_seq (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Control
  input  wire logic               auto_en_i,
  input  wire logic               full_div_i,
  input  wire logic               no_compat_i,
  input  wire logic               advance_i,
  // Mode
  output hcsr_pkg::hcsr_chg_t     mode_o
);

  hcsr_pkg::hcsr_chg_t mode_q;
  hcsr_pkg::hcsr_chg_t after_div;

  // Vendor compatible mode is skipped when excluded
  assign after_div = no_compat_i ? hcsr_pkg::CHG_DCP : hcsr_pkg::CHG_COMPAT;

  always_ff @(posedge clk_i) begin
    if (rst_i || !auto_en_i) begin
      mode_q <= hcsr_pkg::CHG_IDLE;
    end else begin
      unique case (mode_q)
        hcsr_pkg::CHG_IDLE:   mode_q <= full_div_i ? hcsr_pkg::CHG_ACP3 : after_div;
        hcsr_pkg::CHG_ACP3:   if (advance_i) mode_q <= hcsr_pkg::CHG_ACP2;
        hcsr_pkg::CHG_ACP2:   if (advance_i) mode_q <= hcsr_pkg::CHG_ACP1;
        hcsr_pkg::CHG_ACP1:   if (advance_i) mode_q <= after_div;
        hcsr_pkg::CHG_COMPAT: if (advance_i) mode_q <= hcsr_pkg::CHG_DCP;
        hcsr_pkg::CHG_DCP:    mode_q <= hcsr_pkg::CHG_DCP;
        default:              mode_q <= hcsr_pkg::CHG_IDLE;
      endcase
    end
  end

  assign mode_o = mode_q;

endmodule
`default_nettype wire

// [rtl/hcsr_pkg.sv]
// Constants shared by the hub configuration and string register slice.
// Assumes one hub clock and byte-wide register accesses from EEPROM load or SMBus.
package hcsr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] FEAT_ADDR   = 8'h25;
  localparam logic [7:0] MASK_ADDR   = 8'h26;
  localparam logic [7:0] SER_BASE    = 8'h30;
  localparam logic [7:0] SER_LAST    = 8'h4f;
  localparam logic [7:0] MFG_BASE    = 8'h50;
  localparam logic [7:0] MFG_LAST    = 8'h8f;
  localparam int         SER_BYTES   = 32;
  localparam int         MFG_BYTES   = 64;

  // ----------------------------------------
  // Feature configuration byte fields
  // ----------------------------------------
  localparam int         FEAT_LEGACY_BIT  = 4;
  localparam int         FEAT_SLOW_BIT    = 2;
  localparam int         FEAT_NOCOMPAT_BIT = 1;
  localparam int         FEAT_FULLDIV_BIT = 0;
  localparam logic [7:0] FEAT_WMASK       = 8'h17;
  localparam logic [7:0] FEAT_RESET       = 8'h00;

  // ----------------------------------------
  // Port mask byte fields and manufacturer string reset byte
  // ----------------------------------------
  localparam logic [7:0] MASK_WMASK = 8'h0f;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [7:0] MFG_RESET  = 8'h00;

  // ----------------------------------------
  // String descriptors
  // ----------------------------------------
  localparam logic [7:0] SER_INDEX   = 8'h01;
  localparam logic [7:0] MFG_INDEX   = 8'h03;
  localparam logic [6:0] MFG_MAX_LEN = 7'h40;
  localparam logic [6:0] SER_LEN     = 7'h20;

  // Factory serial default: UTF-16LE digits, value arbitrary
  function automatic logic [7:0] ser_default(input int idx);
    ser_default = idx[0] ? 8'h00 : (8'h30 + 8'((idx / 2) % 10));
  endfunction

  // ----------------------------------------
  // Charging attempt sequence, Gray along the full path CHG_IDLE to CHG_DCP with no mode skipped
  // ----------------------------------------
  typedef enum logic [2:0] {
    CHG_IDLE   = 3'h0,
    CHG_ACP3   = 3'h1,
    CHG_ACP2   = 3'h3,
    CHG_ACP1   = 3'h2,
    CHG_COMPAT = 3'h6,
    CHG_DCP    = 3'h7
  } hcsr_chg_t;

endpackage

// [rtl/hcsr_string_store.sv]
// Byte arrays behind the serial-number and manufacturer string registers.
// Assumes write gating is done by the caller; read ports are combinational.
`timescale 1ns/1ps
`default_nettype none
module hcsr_string_store (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Write port
  input  wire logic       ser_we_i,
  input  wire logic       mfg_we_i,
  input  wire logic [5:0] widx_i,
  input  wire logic [7:0] wdata_i,
  // Register read port
  input  wire logic       reg_mfg_i,
  input  wire logic [5:0] reg_idx_i,
  output logic      [7:0] reg_byte_o,
  // Descriptor read port
  input  wire logic       desc_mfg_i,
  input  wire logic [5:0] desc_idx_i,
  output logic      [7:0] desc_byte_o
);

  logic [7:0] ser_q [hcsr_pkg::SER_BYTES];
  logic [7:0] mfg_q [hcsr_pkg::MFG_BYTES];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < hcsr_pkg::SER_BYTES; i++) begin
        ser_q[i] <= hcsr_pkg::ser_default(i);
      end
    end else if (ser_we_i) begin
      ser_q[widx_i[4:0]] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < hcsr_pkg::MFG_BYTES; i++) begin
        mfg_q[i] <= hcsr_pkg::MFG_RESET;
      end
    end else if (mfg_we_i) begin
      mfg_q[widx_i] <= wdata_i;
    end
  end

  assign reg_byte_o  = reg_mfg_i ? mfg_q[reg_idx_i] : ser_q[reg_idx_i[4:0]];
  assign desc_byte_o = desc_mfg_i ? mfg_q[desc_idx_i] : ser_q[desc_idx_i[4:0]];

endmodule
`default_nettype wire

// [rtl/hcsr_top.sv]
// Hub feature configuration, per-port legacy mask and string register slice.
// Assumes byte accesses on the hub clock; fuse inputs are asynchronous straps,
// unlock bits and string length come from other registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hcsr_top (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register access from EEPROM loader or SMBus host
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // Settings held in other registers
  input  wire logic       port_custom_unlock_i,
  input  wire logic       serial_custom_unlock_i,
  input  wire logic [6:0] maker_text_length_i,
  input  wire logic [3:0] port_used_i,
  // Fuse straps
  input  wire logic       fuse_legacy_speed_i,
  input  wire logic       fuse_slow_rate_i,
  input  wire logic       fuse_no_compat_i,
  input  wire logic       fuse_full_div_i,
  // String descriptor fetch
  input  wire logic       desc_rd_i,
  input  wire logic [7:0] desc_index_i,
  input  wire logic [6:0] desc_offset_i,
  output logic      [7:0] desc_byte_o,
  output logic      [6:0] desc_len_o,
  output logic            desc_hit_o,
  output logic            desc_valid_o,
  // Charging control
  input  wire logic       charge_auto_i,
  input  wire logic       charge_advance_i,
  output logic      [2:0] charge_mode_o,
  // Hub behaviour
  output logic            hub_legacy_speed_force_o,
  output logic            ss_speed_advertise_o,
  output logic            usb3_hub_enable_o,
  output logic            two_wire_slow_rate_o,
  output logic            eeprom_slow_rate_o,
  output logic            full_divider_auto_o,
  output logic      [3:0] port_legacy_mask_o,
  output logic      [3:0] port_usb3_enable_o,
  output logic      [3:0] port_usb2_enable_o
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic       hit_ser;
  logic       hit_mfg;
  logic [7:0] ser_off;
  logic [7:0] mfg_off;
  logic [5:0] str_idx;

  assign hit_ser = in_range(reg_addr_i, hcsr_pkg::SER_BASE, hcsr_pkg::SER_LAST);
  assign hit_mfg = in_range(reg_addr_i, hcsr_pkg::MFG_BASE, hcsr_pkg::MFG_LAST);
  assign ser_off = reg_addr_i - hcsr_pkg::SER_BASE;
  assign mfg_off = reg_addr_i - hcsr_pkg::MFG_BASE;
  assign str_idx = hit_mfg ? mfg_off[5:0] : ser_off[5:0];

  // ----------------------------------------
  // Fuse synchronisers
  // ----------------------------------------
  // Straps are asynchronous to the hub clock; two stages before use
  logic [3:0] fuse_meta_q;
  logic [3:0] fuse_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_meta_q <= 4'h0;
      fuse_q      <= 4'h0;
    end else begin
      fuse_meta_q <= {fuse_legacy_speed_i, fuse_slow_rate_i, fuse_no_compat_i, fuse_full_div_i};
      fuse_q      <= fuse_meta_q;
    end
  end

  // ----------------------------------------
  // Feature configuration byte
  // ----------------------------------------
  logic [7:0] feat_q;
  logic [7:0] feat_eff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feat_q <= hcsr_pkg::FEAT_RESET;
    end else if (reg_wr_i && reg_addr_i == hcsr_pkg::FEAT_ADDR) begin
      feat_q <= reg_wdata_i & hcsr_pkg::FEAT_WMASK;
    end
  end

  // Written bit ORed with its fuse for reading and for every effect but the EEPROM slow rate, which takes the fuse alone
  always_comb begin
    feat_eff = feat_q;
    feat_eff[hcsr_pkg::FEAT_LEGACY_BIT]   = feat_q[hcsr_pkg::FEAT_LEGACY_BIT] | fuse_q[3];
    feat_eff[hcsr_pkg::FEAT_SLOW_BIT]     = feat_q[hcsr_pkg::FEAT_SLOW_BIT] | fuse_q[2];
    feat_eff[hcsr_pkg::FEAT_NOCOMPAT_BIT] = feat_q[hcsr_pkg::FEAT_NOCOMPAT_BIT] | fuse_q[1];
    feat_eff[hcsr_pkg::FEAT_FULLDIV_BIT]  = feat_q[hcsr_pkg::FEAT_FULLDIV_BIT] | fuse_q[0];
  end

  // ----------------------------------------
  // Port legacy mask
  // ----------------------------------------
  logic [3:0] mask_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= hcsr_pkg::MASK_RESET;
    end else if (reg_wr_i && reg_addr_i == hcsr_pkg::MASK_ADDR && port_custom_unlock_i) begin
      mask_q <= reg_wdata_i[3:0];
    end
  end

  // ----------------------------------------
  // String arrays
  // ----------------------------------------
  logic       ser_we;
  logic       mfg_we;
  logic [7:0] store_reg_byte;
  logic [7:0] store_desc_byte;
  logic       desc_is_mfg;
  logic       desc_is_ser;
  logic [6:0] mfg_len;

  // Locked serial bytes silently drop the write
  assign ser_we = reg_wr_i && hit_ser && serial_custom_unlock_i;
  assign mfg_we = reg_wr_i && hit_mfg;

  hcsr_string_store u_store (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ser_we_i    (ser_we),
    .mfg_we_i    (mfg_we),
    .widx_i      (str_idx),
    .wdata_i     (reg_wdata_i),
    .reg_mfg_i   (hit_mfg),
    .reg_idx_i   (str_idx),
    .reg_byte_o  (store_reg_byte),
    .desc_mfg_i  (desc_is_mfg),
    .desc_idx_i  (desc_offset_i[5:0]),
    .desc_byte_o (store_desc_byte)
  );

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // Unmapped addresses read as zero so a loader scan never sees stale data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (!reg_rd_i) begin
        reg_rdata_o <= 8'h00;
      end else if (reg_addr_i == hcsr_pkg::FEAT_ADDR) begin
        reg_rdata_o <= feat_eff & hcsr_pkg::FEAT_WMASK;
      end else if (reg_addr_i == hcsr_pkg::MASK_ADDR) begin
        reg_rdata_o <= {4'h0, mask_q};
      end else if (hit_ser || hit_mfg) begin
        reg_rdata_o <= store_reg_byte;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // String descriptor fetch
  // ----------------------------------------
  // Length above the array size is clamped rather than reading past it
  assign mfg_len     = (maker_text_length_i > hcsr_pkg::MFG_MAX_LEN) ?
                       hcsr_pkg::MFG_MAX_LEN : maker_text_length_i;
  assign desc_is_ser = desc_index_i == hcsr_pkg::SER_INDEX;
  assign desc_is_mfg = desc_index_i == hcsr_pkg::MFG_INDEX && mfg_len != 7'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      desc_valid_o <= 1'b0;
      desc_hit_o   <= 1'b0;
      desc_byte_o  <= 8'h00;
      desc_len_o   <= 7'h00;
    end else begin
      desc_valid_o <= desc_rd_i;
      if (desc_rd_i && desc_is_ser) begin
        desc_len_o  <= hcsr_pkg::SER_LEN;
        desc_hit_o  <= desc_offset_i < hcsr_pkg::SER_LEN;
        desc_byte_o <= (desc_offset_i < hcsr_pkg::SER_LEN) ? store_desc_byte : 8'h00;
      end else if (desc_rd_i && desc_is_mfg) begin
        desc_len_o  <= mfg_len;
        desc_hit_o  <= desc_offset_i < mfg_len;
        desc_byte_o <= (desc_offset_i < mfg_len) ? store_desc_byte : 8'h00;
      end else begin
        desc_len_o  <= 7'h00;
        desc_hit_o  <= 1'b0;
        desc_byte_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Charging sequence
  // ----------------------------------------
  hcsr_pkg::hcsr_chg_t chg_mode;

  hcsr_charge_seq u_seq (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .auto_en_i   (charge_auto_i),
    .full_div_i  (feat_eff[hcsr_pkg::FEAT_FULLDIV_BIT]),
    .no_compat_i (feat_eff[hcsr_pkg::FEAT_NOCOMPAT_BIT]),
    .advance_i   (charge_advance_i),
    .mode_o      (chg_mode)
  );

  // ----------------------------------------
  // Behaviour outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_mode_o            <= 3'h0;
      hub_legacy_speed_force_o <= 1'b0;
      ss_speed_advertise_o     <= 1'b1;
      usb3_hub_enable_o        <= 1'b1;
      two_wire_slow_rate_o     <= 1'b0;
      eeprom_slow_rate_o       <= 1'b0;
      full_divider_auto_o      <= 1'b0;
      port_legacy_mask_o       <= 4'h0;
      port_usb3_enable_o       <= 4'h0;
      port_usb2_enable_o       <= 4'h0;
    end else begin
      charge_mode_o            <= chg_mode;
      hub_legacy_speed_force_o <= feat_eff[hcsr_pkg::FEAT_LEGACY_BIT];
      ss_speed_advertise_o     <= !feat_eff[hcsr_pkg::FEAT_LEGACY_BIT];
      usb3_hub_enable_o        <= !feat_eff[hcsr_pkg::FEAT_LEGACY_BIT];
      two_wire_slow_rate_o     <= feat_eff[hcsr_pkg::FEAT_SLOW_BIT];
      eeprom_slow_rate_o       <= fuse_q[2];
      full_divider_auto_o      <= feat_eff[hcsr_pkg::FEAT_FULLDIV_BIT];
      port_legacy_mask_o       <= mask_q;
      // A masked port keeps legacy speed even if the used setting says otherwise
      port_usb3_enable_o       <= port_used_i & ~mask_q
                                  & {4{!feat_eff[hcsr_pkg::FEAT_LEGACY_BIT]}};
      port_usb2_enable_o       <= port_used_i | mask_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_mask_write_locked;
    reg_wr_i && reg_addr_i == hcsr_pkg::MASK_ADDR && !port_custom_unlock_i;
  endsequence

  sequence s_feat_read;
    reg_rd_i && reg_addr_i == hcsr_pkg::FEAT_ADDR;
  endsequence

  a_legacy_drops_ss: assert property (
    hub_legacy_speed_force_o |-> !ss_speed_advertise_o && !usb3_hub_enable_o)
    else $error("legacy force left SuperSpeed active");

  a_slow_rate_or: assert property (
    two_wire_slow_rate_o == $past(feat_q[hcsr_pkg::FEAT_SLOW_BIT] | fuse_q[2]))
    else $error("USB-I2C rate not the OR of bit and fuse");

  a_compat_skipped: assert property (
    feat_eff[hcsr_pkg::FEAT_NOCOMPAT_BIT] && $stable(feat_eff) |=> chg_mode != hcsr_pkg::CHG_COMPAT)
    else $error("excluded compatible mode was attempted");

  a_feat_read_or: assert property (
    s_feat_read |=> reg_rdata_o == ($past(feat_eff) & hcsr_pkg::FEAT_WMASK))
    else $error("feature read is not the fuse OR value");

  a_full_div_first: assert property (
    chg_mode == hcsr_pkg::CHG_IDLE && charge_auto_i && feat_eff[hcsr_pkg::FEAT_FULLDIV_BIT]
    |=> chg_mode == hcsr_pkg::CHG_ACP3)
    else $error("full divider sequence did not start at highest current");

  a_full_div_out: assert property (
    full_divider_auto_o == $past(feat_q[hcsr_pkg::FEAT_FULLDIV_BIT] | fuse_q[0]))
    else $error("full divider enable not the OR of bit and fuse");

  a_feat_reserved: assert property (
    s_feat_read |=> reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[3] == 1'b0)
    else $error("reserved feature bits read nonzero");

  a_mask_locked: assert property (
    s_mask_write_locked |=> $stable(mask_q))
    else $error("locked port mask changed on write");

  a_mask_override: assert property (
    ##1 ((port_usb3_enable_o & $past(mask_q)) == 4'h0))
    else $error("masked port kept SuperSpeed");

  a_mask_upper_zero: assert property (
    reg_rd_i && reg_addr_i == hcsr_pkg::MASK_ADDR |=> reg_rdata_o[7:4] == 4'h0)
    else $error("mask reserved bits read nonzero");

  a_serial_locked: assert property (
    reg_wr_i && hit_ser && !serial_custom_unlock_i ##1 reg_addr_i == $past(reg_addr_i)
    |-> store_reg_byte == $past(store_reg_byte))
    else $error("locked serial byte accepted a write");

  a_maker_len: assert property (
    desc_valid_o && desc_hit_o |-> desc_len_o <= hcsr_pkg::MFG_MAX_LEN && desc_len_o != 7'h00)
    else $error("descriptor length out of range");

endmodule
`default_nettype wire

// [verification/hcsr_host_model.sv]
// Host-side model of the SMBus host or EEPROM loader issuing byte accesses.
// Assumes the register port samples its strobes on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module hcsr_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // ----
  // Byte cycles
  // ----
  // Callers pass string text low byte first at the even address
  // Serial bytes are only meant to stick while the serial unlock is high
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    // Idle data flips so a stale byte is never taken for a fresh one
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    d        = reg_rdata_i;
    v        = reg_rvalid_i;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the hub configuration and string register slice.
// Assumes hcsr_top and the host model; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, desc_index_i, desc_byte_o;
  logic       port_custom_unlock_i, serial_custom_unlock_i, desc_rd_i, desc_hit_o, desc_valid_o;
  logic [6:0] maker_text_length_i, desc_offset_i, desc_len_o;
  logic [3:0] port_used_i, port_legacy_mask_o, port_usb3_enable_o, port_usb2_enable_o;
  logic       fuse_legacy_speed_i, fuse_slow_rate_i, fuse_no_compat_i, fuse_full_div_i;
  logic       charge_auto_i, charge_advance_i, hub_legacy_speed_force_o, ss_speed_advertise_o;
  logic       usb3_hub_enable_o, two_wire_slow_rate_o, eeprom_slow_rate_o, full_divider_auto_o;
  logic [2:0] charge_mode_o;
  int         num_errors = 0;
  int         tests_run  = 0;

  hcsr_top uut (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .port_custom_unlock_i, .serial_custom_unlock_i, .maker_text_length_i, .port_used_i,
    .fuse_legacy_speed_i, .fuse_slow_rate_i, .fuse_no_compat_i, .fuse_full_div_i, .desc_rd_i,
    .desc_index_i, .desc_offset_i, .desc_byte_o, .desc_len_o, .desc_hit_o, .desc_valid_o,
    .charge_auto_i, .charge_advance_i, .charge_mode_o, .hub_legacy_speed_force_o,
    .ss_speed_advertise_o, .usb3_hub_enable_o, .two_wire_slow_rate_o, .eeprom_slow_rate_o,
    .full_divider_auto_o, .port_legacy_mask_o, .port_usb3_enable_o, .port_usb2_enable_o);

  hcsr_host_model host (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----
  // Shared checks
  // ----
  task automatic final_report();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A read that brings no valid strobe turns into an unknown and mismatches
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk((v === 1'b1) ? d : 8'hxx, e);
  endtask

  task automatic desc(input logic [7:0] idx, input logic [6:0] off, input logic [7:0] eb,
                      input logic [6:0] el, input logic eh);
    @(negedge clk_i);
    desc_rd_i     = 1'b1;
    desc_index_i  = idx;
    desc_offset_i = off;
    @(negedge clk_i);
    desc_rd_i = 1'b0;
    chk({desc_hit_o, desc_len_o}, {eh, el});
    chk((desc_valid_o === 1'b1) ? desc_byte_o : 8'hxx, eb);
  endtask

  task automatic step(input logic adv, input logic [2:0] e);
    int i;
    if (adv) begin
      @(negedge clk_i);
      charge_advance_i = 1'b1;
      @(negedge clk_i);
      charge_advance_i = 1'b0;
    end
    for (i = 0; i < 8 && charge_mode_o !== e; i++) @(negedge clk_i);
    chk(charge_mode_o, e);
    if (charge_mode_o !== e) final_report();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk({ss_speed_advertise_o, usb3_hub_enable_o, hub_legacy_speed_force_o}, 3'b110);
    rdc(hcsr_pkg::FEAT_ADDR, 8'h00);
    rdc(hcsr_pkg::MASK_ADDR, 8'h00);
    rdc(hcsr_pkg::SER_BASE, 8'h30);
    rdc(hcsr_pkg::SER_BASE + 8'h01, 8'h00);
    rdc(hcsr_pkg::SER_BASE + 8'h06, 8'h33);
    rdc(hcsr_pkg::MFG_BASE, 8'h00);
    rdc(8'h90, 8'h00);
  endtask

  task automatic t_feat();
    host.wr(hcsr_pkg::FEAT_ADDR, 8'hff);
    rdc(hcsr_pkg::FEAT_ADDR, 8'h17);
    chk({hub_legacy_speed_force_o, ss_speed_advertise_o, usb3_hub_enable_o}, 3'b100);
    chk({two_wire_slow_rate_o, eeprom_slow_rate_o, full_divider_auto_o}, 3'b101);
    host.wr(hcsr_pkg::FEAT_ADDR, 8'h00);
    fuse_no_compat_i = 1'b1;
    fuse_slow_rate_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rdc(hcsr_pkg::FEAT_ADDR, 8'h06);
    chk(eeprom_slow_rate_o, 1'b1);
    fuse_no_compat_i    = 1'b0;
    fuse_slow_rate_i    = 1'b0;
    fuse_full_div_i     = 1'b1;
    fuse_legacy_speed_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rdc(hcsr_pkg::FEAT_ADDR, 8'h11);
    chk({full_divider_auto_o, ss_speed_advertise_o, eeprom_slow_rate_o}, 3'b100);
    fuse_full_div_i     = 1'b0;
    fuse_legacy_speed_i = 1'b0;
    repeat (5) @(negedge clk_i);
  endtask

  task automatic t_mask();
    host.wr(hcsr_pkg::MASK_ADDR, 8'hff);
    rdc(hcsr_pkg::MASK_ADDR, 8'h00);
    port_custom_unlock_i = 1'b1;
    host.wr(hcsr_pkg::MASK_ADDR, 8'hfa);
    rdc(hcsr_pkg::MASK_ADDR, 8'h0a);
    chk(port_legacy_mask_o, 4'ha);
    chk(port_usb3_enable_o, 4'h1);
    chk(port_usb2_enable_o, 4'hb);
    port_custom_unlock_i = 1'b0;
    host.wr(hcsr_pkg::MASK_ADDR, 8'h00);
    rdc(hcsr_pkg::MASK_ADDR, 8'h0a);
  endtask

  task automatic t_strings();
    host.wr(hcsr_pkg::SER_BASE, 8'h55);
    rdc(hcsr_pkg::SER_BASE, 8'h30);
    serial_custom_unlock_i = 1'b1;
    host.wr(hcsr_pkg::SER_LAST, 8'h12);
    rdc(hcsr_pkg::SER_LAST, 8'h12);
    desc(hcsr_pkg::SER_INDEX, 7'h00, 8'h30, hcsr_pkg::SER_LEN, 1'b1);
    desc(hcsr_pkg::SER_INDEX, 7'h1f, 8'h12, hcsr_pkg::SER_LEN, 1'b1);
    host.wr(hcsr_pkg::MFG_BASE, 8'h41);
    host.wr(hcsr_pkg::MFG_BASE + 8'h01, 8'h00);
    desc(hcsr_pkg::MFG_INDEX, 7'h00, 8'h00, 7'h00, 1'b0);
    maker_text_length_i = 7'h02;
    desc(hcsr_pkg::MFG_INDEX, 7'h00, 8'h41, 7'h02, 1'b1);
    desc(hcsr_pkg::MFG_INDEX, 7'h02, 8'h00, 7'h02, 1'b0);
    desc(8'h02, 7'h00, 8'h00, 7'h00, 1'b0);
    maker_text_length_i = 7'h64;
    desc(hcsr_pkg::MFG_INDEX, 7'h01, 8'h00, 7'h40, 1'b1);
  endtask

  task automatic t_charge();
    host.wr(hcsr_pkg::FEAT_ADDR, 8'h01);
    charge_auto_i = 1'b1;
    step(1'b0, hcsr_pkg::CHG_ACP3);
    step(1'b1, hcsr_pkg::CHG_ACP2);
    step(1'b1, hcsr_pkg::CHG_ACP1);
    step(1'b1, hcsr_pkg::CHG_COMPAT);
    step(1'b1, hcsr_pkg::CHG_DCP);
    charge_auto_i = 1'b0;
    step(1'b0, hcsr_pkg::CHG_IDLE);
    host.wr(hcsr_pkg::FEAT_ADDR, 8'h03);
    charge_auto_i = 1'b1;
    step(1'b0, hcsr_pkg::CHG_ACP3);
    step(1'b1, hcsr_pkg::CHG_ACP2);
    step(1'b1, hcsr_pkg::CHG_ACP1);
    step(1'b1, hcsr_pkg::CHG_DCP);
    charge_auto_i = 1'b0;
    step(1'b0, hcsr_pkg::CHG_IDLE);
    host.wr(hcsr_pkg::FEAT_ADDR, 8'h00);
    charge_auto_i = 1'b1;
    step(1'b0, hcsr_pkg::CHG_COMPAT);
    step(1'b1, hcsr_pkg::CHG_DCP);
    charge_auto_i = 1'b0;
    step(1'b0, hcsr_pkg::CHG_IDLE);
    host.wr(hcsr_pkg::FEAT_ADDR, 8'h02);
    charge_auto_i = 1'b1;
    step(1'b0, hcsr_pkg::CHG_DCP);
  endtask

  initial begin
    {rst_i, port_custom_unlock_i, serial_custom_unlock_i, desc_rd_i} = 4'h8;
    {fuse_legacy_speed_i, fuse_slow_rate_i, fuse_no_compat_i, fuse_full_div_i} = 4'h0;
    {charge_auto_i, charge_advance_i, desc_index_i, desc_offset_i} = 17'h00000;
    maker_text_length_i = 7'h00;
    port_used_i         = 4'h3;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_feat();
    t_mask();
    t_strings();
    t_charge();
    final_report();
  end
endmodule
`default_nettype wire
